// *** include/acr_regs.svh ***
// register offsets, fields, reset values and volume map of the control bank
// How it works
// - register 0 returns a fixed 8-bit identity, never altered by writes
// - clip threshold upper six bits sit in power register bits 7:2
// - power bit 1 sleeps power stage, low-voltage standby kept; resets 0
// - power bit 0 low shuts amplifier and both supplies down; resets 1
// - digital bit 7 bypasses the high-pass filter when set; resets 0
// - boost field 5:4 adds 0, 6, 12 or 18 dB; default code 01
// - digital bit 3 picks single (clear) or double (set) rate; resets 0
// - format 0-3 right-justified 24/20/18/16, 4 i2s default, 5 left
// - volume bit 7 enables gradual fading; resets to one
// - volume bit 1 mutes right channel to 50/50 duty; resets 0
// - volume bit 0 mutes left channel the same way; resets 0
// - register 4 is the 8-bit read-write left volume byte
// - volume 0xcf is 0 dB, half-dB steps, below 0x07 mutes
// - write: device address, register address, data; each byte acked
`ifndef ACR_REGS_SVH
`define ACR_REGS_SVH

// ----------------------------------------------------------------
// offsets
// ----------------------------------------------------------------
`define ACR_OFF_ID 8'h00
`define ACR_OFF_PWR 8'h01
`define ACR_OFF_DIG 8'h02
`define ACR_OFF_VCFG 8'h03
`define ACR_OFF_LVOL 8'h04

// ----------------------------------------------------------------
// reset values and writable masks
// ----------------------------------------------------------------
`define ACR_RST_PWR 8'hfd
`define ACR_RST_DIG 8'h14
`define ACR_RST_VCFG 8'h80
`define ACR_RST_LVOL 8'hcf
`define ACR_MASK_DIG 8'hbf
`define ACR_MASK_VCFG 8'h83

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define ACR_PWR_CLIP_HI 7
`define ACR_PWR_CLIP_LO 2
`define ACR_PWR_SLEEP 1
`define ACR_PWR_RUN 0
`define ACR_DIG_HPF 7
`define ACR_DIG_BOOST_HI 5
`define ACR_DIG_BOOST_LO 4
`define ACR_DIG_RATE 3
`define ACR_DIG_FMT_HI 2
`define ACR_DIG_FMT_LO 0
`define ACR_VCFG_FADE 7
`define ACR_VCFG_MUTE_R 1
`define ACR_VCFG_MUTE_L 0

// ----------------------------------------------------------------
// volume map
// ----------------------------------------------------------------
`define ACR_VOL_ZERO_DB 9'h0cf
`define ACR_VOL_FLOOR 8'h07
`define ACR_BOOST_STEP_DB 5'h06

`endif

// *** include/acr_pkg.sv ***
// types shared by the control bank
package acr_pkg;

    // control port sequencer, gray along the usual path
    typedef enum logic [3:0] {
        ST_IDLE = 4'h0,
        ST_ADDR = 4'h1,
        ST_ADDR_ACK = 4'h3,
        ST_REG = 4'h2,
        ST_REG_ACK = 4'h6,
        ST_WR = 4'h7,
        ST_WR_ACK = 4'h5,
        ST_RD = 4'h4,
        ST_RD_ACK = 4'hc
    } acr_state_t;

    typedef enum logic [2:0] {
        FMT_RJ24 = 3'h0,
        FMT_RJ20 = 3'h1,
        FMT_RJ18 = 3'h2,
        FMT_RJ16 = 3'h3,
        FMT_I2S = 3'h4,
        FMT_LJ = 3'h5
    } acr_format_t;

endpackage

// *** hdl/acr_line_sampler.sv ***
// samples one control port line and reports its edges
`timescale 1ns/1ns
module acr_line_sampler #(
    parameter logic IDLE_LEVEL = 1'b1
) (
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // line
    input wire logic line_in,
    // sampled level and edges
    output logic level,
    output logic rise,
    output logic fall
);

    logic now_reg;
    logic prev_reg;

    always_ff @(posedge clk) begin
        if (srst) begin
            now_reg <= IDLE_LEVEL;
            prev_reg <= IDLE_LEVEL;
        end else begin
            now_reg <= line_in;
            prev_reg <= now_reg;
        end
    end

    assign level = now_reg;
    assign rise = now_reg & ~prev_reg;
    assign fall = ~now_reg & prev_reg;

endmodule

// *** hdl/acr_ctrl_bank.sv ***
// control register bank with its two-wire control port
`timescale 1ns/1ns
`include "acr_regs.svh"
module acr_ctrl_bank #(
    parameter logic [6:0] DEV_ADDR = 7'h2a,
    // identity value is arbitrary
    parameter logic [7:0] ID_VALUE = 8'h5a
) (
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // control port, sda is open drain
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    // power controls
    output logic [5:0] clip_threshold_high,
    output logic power_stage_sleep,
    output logic amplifier_run_n_off,
    output logic power_stage_enable,
    // digital path controls
    output logic highpass_skip,
    output logic [1:0] boost_code,
    output logic [4:0] boost_db,
    output logic rate_class_select,
    output logic [2:0] format_code,
    output logic format_is_i2s,
    output logic format_is_left,
    output logic [4:0] format_rj_bits,
    // volume controls
    output logic fade_enable,
    output logic mute_right,
    output logic mute_left,
    output logic [7:0] left_volume,
    output logic signed [8:0] left_gain_half_db,
    output logic left_silent
);

    // ----------------------------------------------------------------
    // line sampling
    // ----------------------------------------------------------------
    logic scl_lvl;
    logic scl_rise;
    logic scl_fall;
    logic sda_lvl;
    logic sda_rise;
    logic sda_fall;

    acr_line_sampler #(.IDLE_LEVEL(1'b1)) u_scl (
        .clk(clk),
        .srst(srst),
        .line_in(scl_in),
        .level(scl_lvl),
        .rise(scl_rise),
        .fall(scl_fall)
    );

    acr_line_sampler #(.IDLE_LEVEL(1'b1)) u_sda (
        .clk(clk),
        .srst(srst),
        .line_in(sda_in),
        .level(sda_lvl),
        .rise(sda_rise),
        .fall(sda_fall)
    );

    // start and stop are seen with scl held high
    wire start_seen = scl_lvl & sda_fall;
    wire stop_seen = scl_lvl & sda_rise;

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    logic [7:0] pwr_reg;
    logic [7:0] dig_reg;
    logic [7:0] vcfg_reg;
    logic [7:0] lvol_reg;

    acr_pkg::acr_state_t state_reg;
    acr_pkg::acr_state_t state_next;
    logic [7:0] shift_reg;
    logic [7:0] shift_next;
    logic [3:0] cnt_reg;
    logic [3:0] cnt_next;
    logic [7:0] ptr_reg;
    logic [7:0] ptr_next;
    logic oe_reg;
    logic oe_next;
    logic wr_stb;

    // ----------------------------------------------------------------
    // read selection, unmapped offsets read zero
    // ----------------------------------------------------------------
    wire hit_id = ptr_reg == `ACR_OFF_ID;
    wire hit_pwr = ptr_reg == `ACR_OFF_PWR;
    wire hit_dig = ptr_reg == `ACR_OFF_DIG;
    wire hit_vcfg = ptr_reg == `ACR_OFF_VCFG;
    wire hit_lvol = ptr_reg == `ACR_OFF_LVOL;

    wire [7:0] rd_data =
        hit_id ? ID_VALUE :
        hit_pwr ? pwr_reg :
        hit_dig ? dig_reg :
        hit_vcfg ? vcfg_reg :
        hit_lvol ? lvol_reg : 8'h00;

    // ----------------------------------------------------------------
    // write decode; identity and reserved bits never take a write
    // ----------------------------------------------------------------
    wire wr_pwr = wr_stb & hit_pwr;
    wire wr_dig = wr_stb & hit_dig;
    wire wr_vcfg = wr_stb & hit_vcfg;
    wire wr_lvol = wr_stb & hit_lvol;

    wire [7:0] dig_wdata = shift_reg & `ACR_MASK_DIG;
    wire [7:0] vcfg_wdata = shift_reg & `ACR_MASK_VCFG;

    always_ff @(posedge clk) begin
        if (srst) begin
            pwr_reg <= `ACR_RST_PWR;
            dig_reg <= `ACR_RST_DIG;
            vcfg_reg <= `ACR_RST_VCFG;
            lvol_reg <= `ACR_RST_LVOL;
        end else begin
            if (wr_pwr) begin
                pwr_reg <= shift_reg;
            end
            if (wr_dig) begin
                dig_reg <= dig_wdata;
            end
            if (wr_vcfg) begin
                vcfg_reg <= vcfg_wdata;
            end
            if (wr_lvol) begin
                lvol_reg <= shift_reg;
            end
        end
    end

    // ----------------------------------------------------------------
    // control port sequencer
    // ----------------------------------------------------------------
    wire addr_match = shift_reg[7:1] == DEV_ADDR;
    wire got_byte = cnt_reg == 4'h8;

    always_comb begin
        state_next = state_reg;
        shift_next = shift_reg;
        cnt_next = cnt_reg;
        ptr_next = ptr_reg;
        oe_next = oe_reg;
        wr_stb = 1'b0;
        if (start_seen) begin
            state_next = acr_pkg::ST_ADDR;
            cnt_next = 4'h0;
            oe_next = 1'b0;
        end else if (stop_seen) begin
            state_next = acr_pkg::ST_IDLE;
            oe_next = 1'b0;
        end else begin
            case (state_reg)
                acr_pkg::ST_IDLE: begin
                    oe_next = 1'b0;
                end
                acr_pkg::ST_ADDR, acr_pkg::ST_REG, acr_pkg::ST_WR: begin
                    if (scl_rise && !got_byte) begin
                        shift_next = {shift_reg[6:0], sda_lvl};
                        cnt_next = cnt_reg + 4'h1;
                    end else if (scl_fall && got_byte) begin
                        cnt_next = 4'h0;
                        oe_next = 1'b1;
                        case (state_reg)
                            acr_pkg::ST_ADDR: begin
                                if (addr_match) begin
                                    state_next = acr_pkg::ST_ADDR_ACK;
                                end else begin
                                    state_next = acr_pkg::ST_IDLE;
                                    oe_next = 1'b0;
                                end
                            end
                            acr_pkg::ST_REG: begin
                                ptr_next = shift_reg;
                                state_next = acr_pkg::ST_REG_ACK;
                            end
                            default: begin
                                wr_stb = 1'b1;
                                ptr_next = ptr_reg + 8'h01;
                                state_next = acr_pkg::ST_WR_ACK;
                            end
                        endcase
                    end
                end
                acr_pkg::ST_ADDR_ACK: begin
                    if (scl_fall) begin
                        if (shift_reg[0]) begin
                            // read: first data bit goes out on this fall
                            shift_next = rd_data;
                            oe_next = ~rd_data[7];
                            ptr_next = ptr_reg + 8'h01;
                            state_next = acr_pkg::ST_RD;
                        end else begin
                            oe_next = 1'b0;
                            state_next = acr_pkg::ST_REG;
                        end
                    end
                end
                acr_pkg::ST_REG_ACK, acr_pkg::ST_WR_ACK: begin
                    if (scl_fall) begin
                        oe_next = 1'b0;
                        state_next = acr_pkg::ST_WR;
                    end
                end
                acr_pkg::ST_RD: begin
                    if (scl_rise) begin
                        cnt_next = cnt_reg + 4'h1;
                    end else if (scl_fall) begin
                        if (cnt_reg == 4'h8) begin
                            cnt_next = 4'h0;
                            oe_next = 1'b0;
                            state_next = acr_pkg::ST_RD_ACK;
                        end else begin
                            shift_next = {shift_reg[6:0], 1'b0};
                            oe_next = ~shift_reg[6];
                        end
                    end
                end
                acr_pkg::ST_RD_ACK: begin
                    if (scl_rise && sda_lvl) begin
                        // master nack ends the read
                        state_next = acr_pkg::ST_IDLE;
                    end else if (scl_fall) begin
                        shift_next = rd_data;
                        oe_next = ~rd_data[7];
                        ptr_next = ptr_reg + 8'h01;
                        state_next = acr_pkg::ST_RD;
                    end
                end
                default: begin
                    state_next = acr_pkg::ST_IDLE;
                    oe_next = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            state_reg <= acr_pkg::ST_IDLE;
            shift_reg <= 8'h00;
            cnt_reg <= 4'h0;
            ptr_reg <= 8'h00;
            oe_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            shift_reg <= shift_next;
            cnt_reg <= cnt_next;
            ptr_reg <= ptr_next;
            oe_reg <= oe_next;
        end
    end

    // open drain: only ever pulls low
    assign sda_out = 1'b0;
    assign sda_oe = oe_reg;

    // ----------------------------------------------------------------
    // power controls
    // ----------------------------------------------------------------
    assign clip_threshold_high =
        pwr_reg[`ACR_PWR_CLIP_HI:`ACR_PWR_CLIP_LO];
    assign power_stage_sleep = pwr_reg[`ACR_PWR_SLEEP];
    assign amplifier_run_n_off = pwr_reg[`ACR_PWR_RUN];
    // sleep drops only the stage; shutdown drops everything
    assign power_stage_enable =
        pwr_reg[`ACR_PWR_RUN] & ~pwr_reg[`ACR_PWR_SLEEP];

    // ----------------------------------------------------------------
    // digital path controls
    // ----------------------------------------------------------------
    assign highpass_skip = dig_reg[`ACR_DIG_HPF];
    assign boost_code =
        dig_reg[`ACR_DIG_BOOST_HI:`ACR_DIG_BOOST_LO];
    // code times six dB
    wire [4:0] boost_x2 = {2'b00, boost_code, 1'b0};
    wire [4:0] boost_x4 = {1'b0, boost_code, 2'b00};
    assign boost_db = boost_x2 + boost_x4;
    assign rate_class_select = dig_reg[`ACR_DIG_RATE];
    assign format_code = dig_reg[`ACR_DIG_FMT_HI:`ACR_DIG_FMT_LO];

    // reserved codes above left-justified decode to nothing valid
    wire [2:0] fc = format_code;
    assign format_is_i2s = fc == acr_pkg::FMT_I2S;
    assign format_is_left = fc == acr_pkg::FMT_LJ;
    assign format_rj_bits =
        (fc == acr_pkg::FMT_RJ24) ? 5'h18 :
        (fc == acr_pkg::FMT_RJ20) ? 5'h14 :
        (fc == acr_pkg::FMT_RJ18) ? 5'h12 :
        (fc == acr_pkg::FMT_RJ16) ? 5'h10 : 5'h00;

    // ----------------------------------------------------------------
    // volume controls
    // ----------------------------------------------------------------
    assign fade_enable = vcfg_reg[`ACR_VCFG_FADE];
    assign mute_right = vcfg_reg[`ACR_VCFG_MUTE_R];
    assign mute_left = vcfg_reg[`ACR_VCFG_MUTE_L];
    assign left_volume = lvol_reg;
    // half-dB steps relative to 0 dB
    assign left_gain_half_db =
        $signed({1'b0, lvol_reg}) - $signed(`ACR_VOL_ZERO_DB);
    assign left_silent =
        (lvol_reg < `ACR_VOL_FLOOR) | mute_left;

endmodule

// *** testbench/acr_host_model.sv ***
// host model driving the two-wire control port of the bank
`timescale 1ns/1ns
module acr_host_model #(
    parameter logic [6:0] DEV = 7'h2a
) (
    // clock
    input wire logic clk,
    // bus lines, sda_pull high pulls the wire low
    input wire logic sda,
    output logic scl,
    output logic sda_pull
);
    initial begin
        scl = 1'b1;
        sda_pull = 1'b0;
    end
    // ----------------------------------------------------------------
    // line sequencing
    // ----------------------------------------------------------------
    // quarter bit of 4 clk keeps scl well under an eighth of clk
    task automatic q;
        repeat (4) @(posedge clk);
        #1;
    endtask
    task automatic start;
        sda_pull = 1'b0;
        q;
        scl = 1'b1;
        q;
        sda_pull = 1'b1;
        q;
        scl = 1'b0;
        q;
    endtask
    task automatic stop;
        sda_pull = 1'b1;
        q;
        scl = 1'b1;
        q;
        sda_pull = 1'b0;
        q;
        q;
    endtask
    task automatic bit_x(input logic b, output logic r);
        sda_pull = ~b;
        q;
        scl = 1'b1;
        q;
        r = sda;
        q;
        scl = 1'b0;
        q;
    endtask
    // ninth bit is released, so it reads the ack or sends a nack
    task automatic byte_x(input logic [7:0] d, output logic [7:0] r,
                          output logic ack);
        logic v;
        for (int i = 7; i >= 0; i--) begin
            bit_x(d[i], v);
            r[i] = v;
        end
        bit_x(1'b1, v);
        ack = ~v;
    endtask
    // ----------------------------------------------------------------
    // register transfers
    // ----------------------------------------------------------------
    task automatic write_reg(input logic [6:0] dev, input logic [7:0] a,
                             input logic [7:0] d, output logic ok);
        logic [7:0] r;
        logic k1, k2, k3;
        start;
        byte_x({dev, 1'b0}, r, k1);
        byte_x(a, r, k2);
        byte_x(d, r, k3);
        stop;
        ok = k1 & k2 & k3;
    endtask
    task automatic read_reg(input logic [7:0] a, output logic [7:0] d,
                            output logic ok);
        logic [7:0] r;
        logic k1, k2, k3, k4;
        start;
        byte_x({DEV, 1'b0}, r, k1);
        byte_x(a, r, k2);
        start;
        byte_x({DEV, 1'b1}, r, k3);
        byte_x(8'hff, d, k4);
        stop;
        ok = k1 & k2 & k3;
    endtask
endmodule

// *** testbench/acr_ctrl_bank_sva.sv ***
// port checker for the control register bank
`timescale 1ns/1ns
module acr_ctrl_bank_sva (
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // control port
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe,
    // controls
    input wire logic [5:0] clip_threshold_high,
    input wire logic power_stage_sleep,
    input wire logic amplifier_run_n_off,
    input wire logic power_stage_enable,
    input wire logic highpass_skip,
    input wire logic [1:0] boost_code,
    input wire logic [4:0] boost_db,
    input wire logic rate_class_select,
    input wire logic [2:0] format_code,
    input wire logic format_is_i2s,
    input wire logic format_is_left,
    input wire logic [4:0] format_rj_bits,
    input wire logic fade_enable,
    input wire logic mute_right,
    input wire logic mute_left,
    input wire logic [7:0] left_volume,
    input wire logic signed [8:0] left_gain_half_db,
    input wire logic left_silent
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    logic [25:0] regs_now;
    assign regs_now = {clip_threshold_high, power_stage_sleep,
        amplifier_run_n_off, highpass_skip, boost_code, rate_class_select,
        format_code, fade_enable, mute_right, mute_left, left_volume};
    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    reset_values_a: assert property (
        $fell(srst) |-> regs_now == 26'h3f4a4cf)
        else $error("reset values wrong");
    write_on_ack_a: assert property (
        $changed(regs_now) |-> $rose(sda_oe))
        else $error("register moved outside an ack");
    oe_scl_low_a: assert property (
        $changed(sda_oe) |-> !scl_in)
        else $error("sda enable moved while scl high");
    open_drain_a: assert property (
        sda_oe |-> !sda_out)
        else $error("sda driven high");
    stage_gate_a: assert property (
        power_stage_enable == (amplifier_run_n_off & ~power_stage_sleep))
        else $error("power stage enable wrong");
    boost_gain_a: assert property (
        boost_db == 5'(boost_code) * 5'h06)
        else $error("boost gain wrong");
    format_flags_a: assert property (
        {format_is_i2s, format_is_left} ==
        {format_code == 3'h4, format_code == 3'h5})
        else $error("format flags wrong");
    format_width_a: assert property (
        format_rj_bits == ((format_code == 3'h0) ? 5'h18 :
        (format_code == 3'h1) ? 5'h14 : (format_code == 3'h2) ? 5'h12 :
        (format_code == 3'h3) ? 5'h10 : 5'h00))
        else $error("format width wrong");
    volume_gain_a: assert property (
        left_gain_half_db == 9'({1'b0, left_volume}) - 9'h0cf)
        else $error("volume gain wrong");
    volume_silent_a: assert property (
        left_silent == ((left_volume < 8'h07) | mute_left))
        else $error("silent flag wrong");
endmodule

bind acr_ctrl_bank acr_ctrl_bank_sva chk_u (.clk(clk), .srst(srst),
    .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
    .clip_threshold_high(clip_threshold_high),
    .power_stage_sleep(power_stage_sleep),
    .amplifier_run_n_off(amplifier_run_n_off),
    .power_stage_enable(power_stage_enable), .highpass_skip(highpass_skip),
    .boost_code(boost_code), .boost_db(boost_db),
    .rate_class_select(rate_class_select), .format_code(format_code),
    .format_is_i2s(format_is_i2s), .format_is_left(format_is_left),
    .format_rj_bits(format_rj_bits), .fade_enable(fade_enable),
    .mute_right(mute_right), .mute_left(mute_left),
    .left_volume(left_volume), .left_gain_half_db(left_gain_half_db),
    .left_silent(left_silent));

// *** testbench/acr_ctrl_bank_tb.sv ***
// self-checking bench for the control register bank
`timescale 1ns/1ns
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin \
    $display("CHECK FAILED %s exp %h got %h", nm, e, g); err_total++; end end
module acr_ctrl_bank_tb;
    localparam logic [6:0] DEV = 7'h2a;
    // identity value is arbitrary
    localparam logic [7:0] ID = 8'h3c;
    logic clk, srst, scl_in, sda_pull, sda_out, sda_oe, sda_in;
    logic power_stage_sleep, amplifier_run_n_off, power_stage_enable;
    logic highpass_skip, rate_class_select, format_is_i2s, format_is_left;
    logic fade_enable, mute_right, mute_left, left_silent;
    logic [5:0] clip_threshold_high;
    logic [1:0] boost_code;
    logic [4:0] boost_db, format_rj_bits;
    logic [2:0] format_code;
    logic [7:0] left_volume;
    logic signed [8:0] left_gain_half_db;
    logic [18:0] dig_now;
    logic [7:0] flags_now;
    logic [8:0] pwr_now;
    logic [3:0] vol_now;
    int err_total = 0, n_checks = 0, cyc = 0;
    // pull-up wire: low when either party pulls
    assign sda_in = ~sda_pull & ~(sda_oe & ~sda_out);
    assign dig_now = {highpass_skip, boost_code, boost_db, rate_class_select,
        format_code, format_is_i2s, format_is_left, format_rj_bits};
    assign flags_now = {power_stage_enable, boost_db, format_is_i2s,
        left_silent};
    assign pwr_now = {clip_threshold_high, power_stage_sleep,
        amplifier_run_n_off, power_stage_enable};
    assign vol_now = {fade_enable, mute_right, mute_left, left_silent};
    acr_host_model #(.DEV(DEV)) host_u (.clk(clk), .sda(sda_in),
        .scl(scl_in), .sda_pull(sda_pull));
    acr_ctrl_bank #(.DEV_ADDR(DEV), .ID_VALUE(ID)) dut_u (.clk(clk),
        .srst(srst), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
        .sda_oe(sda_oe), .clip_threshold_high(clip_threshold_high),
        .power_stage_sleep(power_stage_sleep),
        .amplifier_run_n_off(amplifier_run_n_off),
        .power_stage_enable(power_stage_enable),
        .highpass_skip(highpass_skip), .boost_code(boost_code),
        .boost_db(boost_db), .rate_class_select(rate_class_select),
        .format_code(format_code), .format_is_i2s(format_is_i2s),
        .format_is_left(format_is_left), .format_rj_bits(format_rj_bits),
        .fade_enable(fade_enable), .mute_right(mute_right),
        .mute_left(mute_left), .left_volume(left_volume),
        .left_gain_half_db(left_gain_half_db), .left_silent(left_silent));
    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic ok;
        host_u.write_reg(DEV, a, d, ok);
        `CHK("write ack", 1'b1, ok)
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        logic ok;
        logic [7:0] d;
        host_u.read_reg(a, d, ok);
        `CHK("read ack", 1'b1, ok)
        `CHK("read data", e, d)
    endtask
    task automatic final_report;
        $display("checks %0d errors %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_reset;
        `CHK("reset flags", 8'h9a, flags_now)
        rd(8'h00, ID);
        rd(8'h01, 8'hfd);
        rd(8'h02, 8'h14);
        rd(8'h03, 8'h80);
        rd(8'h04, 8'hcf);
        rd(8'h07, 8'h00);
    endtask
    task automatic t_ident;
        wr(8'h00, 8'hff);
        rd(8'h00, ID);
    endtask
    task automatic t_power;
        wr(8'h01, 8'h82);
        `CHK("power", 9'h104, pwr_now)
        rd(8'h01, 8'h82);
        wr(8'h01, 8'h7d);
        `CHK("power", 9'h0fb, pwr_now)
    endtask
    task automatic t_digital;
        logic [2:0] f;
        logic [7:0] d;
        logic [4:0] rj;
        logic [18:0] x;
        for (int i = 0; i < 6; i++) begin
            f = 3'(i);
            d = {f[0], 1'b0, f[1:0], f[1], f};
            wr(8'h02, d);
            rj = (f == 3'h0) ? 5'h18 : (f == 3'h1) ? 5'h14 :
                (f == 3'h2) ? 5'h12 : (f == 3'h3) ? 5'h10 : 5'h00;
            x = {f[0], f[1:0], 5'(f[1:0]) * 5'h06, f[1], f, f == 3'h4,
                f == 3'h5, rj};
            `CHK("digital", x, dig_now)
            rd(8'h02, d);
        end
    endtask
    task automatic t_reserved;
        wr(8'h02, 8'hfd);
        rd(8'h02, 8'hbd);
        wr(8'h03, 8'hff);
        rd(8'h03, 8'h83);
        `CHK("volume cfg", 4'hf, vol_now)
        wr(8'h03, 8'h00);
        `CHK("volume cfg", 4'h0, vol_now)
    endtask
    task automatic t_volume;
        logic [7:0] v [4];
        v = '{8'h06, 8'h07, 8'hff, 8'hcf};
        for (int i = 0; i < 4; i++) begin
            wr(8'h04, v[i]);
            `CHK("gain", {1'b0, v[i]} - 9'h0cf, left_gain_half_db)
            `CHK("silent", v[i] < 8'h07, left_silent)
            rd(8'h04, v[i]);
        end
    endtask
    task automatic t_foreign;
        logic ok;
        host_u.write_reg(DEV ^ 7'h01, 8'h04, 8'h11, ok);
        `CHK("foreign ack", 1'b0, ok)
        `CHK("volume kept", 8'hcf, left_volume)
    endtask
    // ----------------------------------------------------------------
    // run
    // ----------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            err_total++;
            final_report;
        end
    end
    initial begin
        srst = 1'b1;
        repeat (16) @(posedge clk);
        #1 srst = 1'b0;
        repeat (3) @(posedge clk);
        t_reset;
        t_ident;
        t_power;
        t_digital;
        t_reserved;
        t_volume;
        t_foreign;
        final_report;
    end
endmodule
